/* design/titst_pkg.sv */
// shared constants and types of the terminal interrupt, time tag and self-test block
package titst_pkg;
  localparam int CLK_MHZ = 250;
  localparam int TT_W = 16;
  localparam logic [15:0] TT_RST = 16'h0000;
  localparam logic [15:0] TT_MAX = 16'hFFFF;
  localparam int TT_MIN_US = 2;
  localparam int PST_CYCLES = 32000;
  localparam int ROM_AW = 12;
  localparam int ROM_W = 24;
  localparam int ISQ_AW = 6;
  localparam int RAM_AW = 12;
  localparam int IS1_TT_ROLL = 6;
  localparam int IS1_PARITY = 15;
  localparam int IS2_CHAIN = 0;
  localparam int IS2_SELFTEST = 1;
  localparam int IS2_USER_LSB = 2;
  localparam int BIT_FAIL_POS = 8;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] ISQ_PAR_TAG = 16'h8000;
  typedef enum logic [1:0] {FREQ_10 = 2'b00, FREQ_12 = 2'b01, FREQ_16 = 2'b10, FREQ_20 = 2'b11} titst_freq_type;
  typedef enum logic [1:0] {INT_PULSE = 2'b00, INT_LEVEL_SW = 2'b01, INT_LEVEL_AUTO = 2'b10} titst_int_type;
  typedef enum logic [1:0] {MODE_BC = 2'b00, MODE_RT = 2'b01, MODE_MON = 2'b10, MODE_RT_MON = 2'b11} titst_mode_type;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PROT = 2'b01, ST_PWAIT = 2'b10, ST_RAM = 2'b11} titst_st_type;
  function automatic logic [4:0] titst_mhz(input logic [1:0] sel);
    case (sel)
      FREQ_10: titst_mhz = 5'd10;
      FREQ_12: titst_mhz = 5'd12;
      FREQ_16: titst_mhz = 5'd16;
      default: titst_mhz = 5'd20;
    endcase
  endfunction
endpackage

/* design/titst_if.sv */
// carriers between the top and its time tag and ram test modules
`timescale 1ns/1ps
`default_nettype none
interface titst_tt_if;
  logic clr;
  logic load;
  logic [15:0] load_val;
  logic sw_mode;
  logic sw_inc;
  logic [2:0] res;
  logic [1:0] freq;
  logic [15:0] count;
  logic roll;
  logic term_en;
  logic samp_en;
  modport ctl (output clr, load, load_val, sw_mode, sw_inc, res, freq,
               input count, roll, term_en, samp_en);
  modport tt (input clr, load, load_val, sw_mode, sw_inc, res, freq,
              output count, roll, term_en, samp_en);
endinterface
interface titst_ram_if;
  logic start;
  logic busy;
  logic done;
  logic fail;
  logic par_err;
  logic [11:0] par_addr;
  modport ctl (output start, input busy, done, fail, par_err, par_addr);
  modport ram (input start, output busy, done, fail, par_err, par_addr);
endinterface
`default_nettype wire

/* design/titst_timetag.sv */
// time tag counter with clock-rate derived prescaler
`timescale 1ns/1ps
`default_nettype none
module titst_timetag import titst_pkg::*; #(
  parameter int CLK_RATE = CLK_MHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // control side
  titst_tt_if.tt tt
);
  logic [8:0] acc, acc2;
  logic [4:0] us_cnt;
  logic [5:0] res_cnt;
  logic [4:0] mhz;
  logic [9:0] sum, sum2;
  logic us_tick, inc;
  assign mhz = titst_mhz(tt.freq);
  assign sum = {1'b0, acc} + {5'b0, mhz};
  assign sum2 = {1'b0, acc2} + {4'b0, mhz, 1'b0};
  assign us_tick = tt.term_en && (us_cnt == mhz - 5'd1);
  // phase accumulators give exact average terminal and double sampling rates
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc <= '0;
      acc2 <= '0;
      tt.term_en <= 1'b0;
      tt.samp_en <= 1'b0;
    end else begin
      tt.term_en <= sum >= 10'(CLK_RATE);
      acc <= (sum >= 10'(CLK_RATE)) ? 9'(sum - 10'(CLK_RATE)) : sum[8:0];
      tt.samp_en <= sum2 >= 10'(CLK_RATE);
      acc2 <= (sum2 >= 10'(CLK_RATE)) ? 9'(sum2 - 10'(CLK_RATE)) : sum2[8:0];
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      us_cnt <= '0;
      res_cnt <= '0;
    end else if (tt.term_en) begin
      us_cnt <= us_tick ? 5'd0 : us_cnt + 5'd1;
      if (us_tick) begin
        res_cnt <= inc ? 6'd0 : res_cnt + 6'd1;
      end
    end
  end
  // count every 2<<res microseconds (64 for res 6 and 7, as res_cnt is 6 bits), or on software strobe
  assign inc = tt.sw_mode ? tt.sw_inc :
               us_tick && (res_cnt == 6'((TT_MIN_US << tt.res) - 1));
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tt.count <= TT_RST;
      tt.roll <= 1'b0;
    end else begin
      tt.roll <= 1'b0;
      if (tt.clr) begin
        tt.count <= TT_RST;
      end else if (tt.load) begin
        tt.count <= tt.load_val;
      end else if (inc) begin
        tt.count <= tt.count + 16'h0001;
        tt.roll <= tt.count == TT_MAX;
      end
    end
  end
endmodule
`default_nettype wire

/* design/titst_ram_bist.sv */
// shared ram port with parity and the address / inverted-address ram test
`timescale 1ns/1ps
`default_nettype none
module titst_ram_bist import titst_pkg::*; #(
  parameter int AW = RAM_AW
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // test control
  titst_ram_if.ram rt,
  // user access, ignored while the test runs
  input wire logic usr_req_i,
  input wire logic usr_we_i,
  input wire logic [AW-1:0] usr_addr_i,
  input wire logic [15:0] usr_wdata_i,
  output logic usr_rvalid_o,
  output logic [15:0] usr_rdata_o,
  // ram pins, 17 bits with parity on top
  output logic [AW-1:0] ram_addr_o,
  output logic ram_we_o,
  output logic ram_re_o,
  output logic [16:0] ram_wdata_o,
  input wire logic [16:0] ram_rdata_i
);
  logic [1:0] pass;
  logic [AW-1:0] idx;
  logic rd_pend, rd_bist;
  logic [15:0] exp_q;
  logic [AW-1:0] addr_q;
  logic [15:0] pat;
  assign pat = pass[1] ? ~16'(idx) : 16'(idx);
  // even parity generated on every write
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ram_addr_o <= '0;
      ram_we_o <= 1'b0;
      ram_re_o <= 1'b0;
      ram_wdata_o <= '0;
    end else if (rt.busy) begin
      ram_addr_o <= idx;
      ram_we_o <= !pass[0];
      ram_re_o <= pass[0];
      ram_wdata_o <= {^pat, pat};
    end else begin
      ram_addr_o <= usr_addr_i;
      ram_we_o <= usr_req_i && usr_we_i;
      ram_re_o <= usr_req_i && !usr_we_i;
      ram_wdata_o <= {^usr_wdata_i, usr_wdata_i};
    end
  end
  // passes: write addr, check addr, write ~addr, check ~addr
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rt.busy <= 1'b0;
      rt.done <= 1'b0;
      rt.fail <= 1'b0;
      pass <= '0;
      idx <= '0;
    end else begin
      rt.done <= 1'b0;
      if (!rt.busy && rt.start) begin
        rt.busy <= 1'b1;
        rt.fail <= 1'b0;
        pass <= '0;
        idx <= '0;
      end else if (rt.busy) begin
        idx <= idx + 1'b1;
        if (&idx) begin
          pass <= pass + 2'd1;
          if (pass == 2'd3) begin
            rt.busy <= 1'b0;
            rt.done <= 1'b1;
          end
        end
      end
      if (rd_pend && rd_bist && ram_rdata_i[15:0] != exp_q) begin
        rt.fail <= 1'b1;
      end
    end
  end
  // one cycle read latency: check data and parity the cycle after the strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_pend <= 1'b0;
      rd_bist <= 1'b0;
      exp_q <= '0;
      addr_q <= '0;
      usr_rvalid_o <= 1'b0;
      usr_rdata_o <= '0;
      rt.par_err <= 1'b0;
      rt.par_addr <= '0;
    end else begin
      rd_pend <= ram_re_o;
      rd_bist <= rt.busy ? |{pass, idx} : rt.done;
      exp_q <= ram_wdata_o[15:0];
      addr_q <= ram_addr_o;
      usr_rvalid_o <= rd_pend && !rd_bist;
      usr_rdata_o <= ram_rdata_i[15:0];
      rt.par_err <= rd_pend && (^ram_rdata_i);
      rt.par_addr <= 12'(addr_q);
    end
  end
endmodule
`default_nettype wire

/* design/titst_top.sv */
// interrupt generator, time tag, self-test sequencing and decoder sampling
// Behaviour
// - decoders sample at twice terminal clock; single-ended option
// - 16-bit time tag, 2 to 64 us
// - software strobe may replace timed increments
// - time tag written per bc/rt message
// - time tag wrap sets status and interrupt
// - rt sync clears or loads time tag
// - filtered sync loads only if bit0 zero
// - bc sends time tag as sync data
// - sequencer loads time tag, queues its value
// - interrupt pulse, software level or auto-clear level
// - standard mode masks status; masks gate output
// - status2 bit0 chains any status1 event
// - four user interrupts in enhanced bc
// - rt/monitor interrupt queue with validity filter
// - protocol test toggles registers, about 32000 cycles
// - ram test writes/checks address, inverted address
// - protocol test at power-up; host starts tests
// - rt bit word bit 8 reports failure
// - passed test restores registers; time tag runs
// - failed test exposes first failing vector
// - ram test leaves ram altered
// - parity on ram writes, checked on reads
// - timing derived from selected input clock
`timescale 1ns/1ps
`default_nettype none
module titst_top import titst_pkg::*; #(
  parameter int PST_LEN = PST_CYCLES,
  parameter int CLK_RATE = CLK_MHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // configuration
  input wire logic [1:0] mode_i,
  input wire logic [1:0] freq_sel_i,
  input wire logic [1:0] int_mode_i,
  input wire logic enh_int_i,
  input wire logic enh_bc_i,
  input wire logic single_ended_i,
  // receiver pins
  input wire logic rx_pos_i,
  input wire logic rx_neg_i,
  output logic dec_pos_o,
  output logic dec_neg_o,
  // interrupt registers
  input wire logic mask1_we_i,
  input wire logic mask2_we_i,
  input wire logic [15:0] mask_wdata_i,
  input wire logic stat1_rd_i,
  input wire logic stat2_rd_i,
  input wire logic int_clear_i,
  input wire logic [15:0] evt1_i,
  input wire logic [15:0] evt2_i,
  input wire logic [3:0] user_irq_i,
  output logic [15:0] mask1_o,
  output logic [15:0] mask2_o,
  output logic [15:0] stat1_o,
  output logic [15:0] stat2_o,
  output logic int_o,
  // time tag
  input wire logic [2:0] tt_res_i,
  input wire logic tt_sw_mode_i,
  input wire logic tt_sw_inc_i,
  input wire logic tt_we_i,
  input wire logic [15:0] tt_wdata_i,
  input wire logic sync_clr_en_i,
  input wire logic sync_load_en_i,
  input wire logic sync_filter_i,
  input wire logic sync_nodata_i,
  input wire logic sync_data_i,
  input wire logic [15:0] sync_word_i,
  input wire logic seq_tt_load_i,
  input wire logic [15:0] seq_tt_value_i,
  input wire logic seq_tt_queue_i,
  output logic [15:0] tt_count_o,
  output logic [15:0] bc_sync_word_o,
  output logic gpq_we_o,
  output logic [15:0] gpq_data_o,
  // message events
  input wire logic msg_done_i,
  input wire logic msg_valid_i,
  input wire logic msg_irq_i,
  input wire logic [15:0] msg_status_i,
  input wire logic [15:0] msg_desc_i,
  input wire logic isq_valid_en_i,
  input wire logic isq_invalid_en_i,
  input wire logic [ISQ_AW-1:0] isq_raddr_i,
  output logic desc_tt_we_o,
  output logic [15:0] desc_tt_o,
  output logic [15:0] isq_rdata_o,
  output logic [ISQ_AW-1:0] isq_wptr_o,
  // self-test
  input wire logic st_start_i,
  input wire logic st_ram_sel_i,
  output logic st_busy_o,
  output logic st_prot_fail_o,
  output logic st_ram_fail_o,
  output logic [15:0] rt_bit_word_o,
  output logic [11:0] fail_rom_addr_o,
  output logic [23:0] fail_expect_o,
  output logic [5:0] fail_target_o,
  output logic [15:0] fail_actual_o,
  // shared ram
  input wire logic ram_req_i,
  input wire logic ram_we_i,
  input wire logic [RAM_AW-1:0] ram_addr_i,
  input wire logic [15:0] ram_wdata_i,
  output logic ram_rvalid_o,
  output logic [15:0] ram_rdata_o,
  output logic [RAM_AW-1:0] ram_addr_o,
  output logic ram_we_o,
  output logic ram_re_o,
  output logic [16:0] ram_wdata_o,
  input wire logic [16:0] ram_rdata_i
);
  titst_tt_if tti();
  titst_ram_if rmi();
  titst_st_type st;
  logic [1:0] pos_s, neg_s;
  logic is_bc, is_rt, is_rtmon;
  logic [15:0] ev1, ev2, set1, set2;
  logic clr, pend_set, pending, por;
  logic [ROM_AW-1:0] vec;
  logic vph;
  logic [15:0] sav1, sav2, pat, rb;
  logic [15:0] pst_cnt;
  logic [15:0] isq [0:(1<<ISQ_AW)-1];
  logic par_pend;
  logic [11:0] par_addr_q;
  logic isq_msg, isq_par;
  assign is_bc = mode_i == MODE_BC;
  assign is_rt = mode_i == MODE_RT || mode_i == MODE_RT_MON;
  assign is_rtmon = mode_i != MODE_BC;
  titst_timetag #(.CLK_RATE(CLK_RATE)) u_tt (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tt(tti)
  );
  titst_ram_bist #(.AW(RAM_AW)) u_ram (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .rt(rmi),
    .usr_req_i(ram_req_i),
    .usr_we_i(ram_we_i),
    .usr_addr_i(ram_addr_i),
    .usr_wdata_i(ram_wdata_i),
    .usr_rvalid_o(ram_rvalid_o),
    .usr_rdata_o(ram_rdata_o),
    .ram_addr_o(ram_addr_o),
    .ram_we_o(ram_we_o),
    .ram_re_o(ram_re_o),
    .ram_wdata_o(ram_wdata_o),
    .ram_rdata_i(ram_rdata_i)
  );
  // receiver pins are asynchronous: two flops before sampling
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_s <= '0;
      neg_s <= '0;
      dec_pos_o <= 1'b0;
      dec_neg_o <= 1'b0;
    end else begin
      pos_s <= {pos_s[0], rx_pos_i};
      neg_s <= {neg_s[0], rx_neg_i};
      if (tti.samp_en) begin
        dec_pos_o <= pos_s[1];
        dec_neg_o <= single_ended_i ? !pos_s[1] : neg_s[1];
      end
    end
  end
  // time tag control
  assign tti.freq = freq_sel_i;
  assign tti.res = tt_res_i;
  assign tti.sw_mode = tt_sw_mode_i;
  assign tti.sw_inc = tt_sw_inc_i;
  assign tti.clr = is_rt && sync_clr_en_i && sync_nodata_i;
  always_comb begin
    tti.load = 1'b0;
    tti.load_val = tt_wdata_i;
    if (tt_we_i) begin
      tti.load = 1'b1;
    end else if (is_bc && seq_tt_load_i) begin
      tti.load = 1'b1;
      tti.load_val = seq_tt_value_i;
    end else if (is_rt && sync_load_en_i && sync_data_i && !(sync_filter_i && sync_word_i[0])) begin
      tti.load = 1'b1;
      tti.load_val = sync_word_i;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tt_count_o <= TT_RST;
      bc_sync_word_o <= TT_RST;
      gpq_we_o <= 1'b0;
      gpq_data_o <= '0;
      desc_tt_we_o <= 1'b0;
      desc_tt_o <= '0;
    end else begin
      tt_count_o <= tti.count;
      bc_sync_word_o <= tti.count;
      gpq_we_o <= is_bc && seq_tt_queue_i;
      gpq_data_o <= tti.count;
      desc_tt_we_o <= msg_done_i && mode_i != MODE_MON;
      desc_tt_o <= tti.count;
    end
  end
  // interrupt status: standard mode filters by mask, enhanced does not
  always_comb begin
    ev1 = evt1_i;
    ev1[IS1_TT_ROLL] = evt1_i[IS1_TT_ROLL] | tti.roll;
    ev1[IS1_PARITY] = evt1_i[IS1_PARITY] | rmi.par_err;
    ev2 = evt2_i;
    ev2[IS2_SELFTEST] = evt2_i[IS2_SELFTEST] | rmi.done | (st == ST_PWAIT && pst_cnt >= 16'(PST_LEN));
    ev2[IS2_USER_LSB +: 4] = evt2_i[IS2_USER_LSB +: 4] | (is_bc && enh_bc_i ? user_irq_i : 4'h0);
    set1 = enh_int_i ? ev1 : ev1 & mask1_o;
    ev2[IS2_CHAIN] = |set1;
    set2 = enh_int_i ? ev2 : ev2 & mask2_o;
    set2[IS2_CHAIN] = |set1;
  end
  assign clr = int_clear_i || (int_mode_i == INT_LEVEL_AUTO && (stat1_rd_i || stat2_rd_i));
  assign pend_set = |(set1 & mask1_o) || |(set2 & mask2_o);
  assign pending = |(stat1_o & mask1_o) || |(stat2_o & mask2_o);
  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat1_o <= '0;
      stat2_o <= '0;
    end else begin
      stat1_o <= (clr ? 16'h0000 : stat1_o) | set1;
      stat2_o <= (clr ? 16'h0000 : stat2_o) | set2;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_o <= 1'b0;
    end else if (int_mode_i == INT_PULSE) begin
      int_o <= pend_set;
    end else begin
      int_o <= (pending && !clr) || pend_set;
    end
  end
  // masks: host writes are held off while the protocol test owns them
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask1_o <= MASK_RST;
      mask2_o <= MASK_RST;
    end else if (st == ST_PROT) begin
      if (!vph && !vec[0]) begin
        mask1_o <= pat;
      end
      if (!vph && vec[0]) begin
        mask2_o <= pat;
      end
      if (vph && &vec) begin
        mask1_o <= sav1;
        mask2_o <= sav2;
      end
    end else begin
      if (mask1_we_i) begin
        mask1_o <= mask_wdata_i;
      end
      if (mask2_we_i) begin
        mask2_o <= mask_wdata_i;
      end
    end
  end
  // self-test sequencing; time tag keeps counting throughout
  assign pat = {vec[3:0], ~vec};
  assign rb = vec[0] ? mask2_o : mask1_o;
  assign rmi.start = st == ST_IDLE && !por && st_start_i && st_ram_sel_i;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= ST_IDLE;
      por <= 1'b1;
      vec <= '0;
      vph <= 1'b0;
      sav1 <= '0;
      sav2 <= '0;
      pst_cnt <= '0;
      st_prot_fail_o <= 1'b0;
      fail_rom_addr_o <= '0;
      fail_expect_o <= '0;
      fail_target_o <= '0;
      fail_actual_o <= '0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (por || (st_start_i && !st_ram_sel_i)) begin
            st <= ST_PROT;
            por <= 1'b0;
            vec <= '0;
            vph <= 1'b0;
            pst_cnt <= '0;
            sav1 <= mask1_o;
            sav2 <= mask2_o;
            st_prot_fail_o <= 1'b0;
          end else if (st_start_i) begin
            st <= ST_RAM;
          end
        end
        ST_PROT: begin
          vph <= !vph;
          if (vph) begin
            vec <= vec + 1'b1;
            if (rb != pat && !st_prot_fail_o) begin
              st_prot_fail_o <= 1'b1;
              fail_rom_addr_o <= vec;
              fail_expect_o <= {6'(vec[0]), 2'b00, pat};
              fail_target_o <= 6'(vec[0]);
              fail_actual_o <= rb;
            end
            if (&vec) begin
              st <= ST_PWAIT;
            end
          end
        end
        ST_PWAIT: begin
          if (pst_cnt >= 16'(PST_LEN)) begin
            st <= ST_IDLE;
          end
        end
        ST_RAM: begin
          if (rmi.done) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
      if (st != ST_IDLE && st != ST_RAM && tti.term_en) begin
        pst_cnt <= pst_cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_busy_o <= 1'b0;
      st_ram_fail_o <= 1'b0;
      rt_bit_word_o <= '0;
    end else begin
      st_busy_o <= st != ST_IDLE || por;
      st_ram_fail_o <= rmi.fail;
      rt_bit_word_o <= is_rt ? 16'((st_prot_fail_o | rmi.fail) << BIT_FAIL_POS) : 16'h0000;
    end
  end
  // interrupt status queue, two words per entry
  assign isq_msg = msg_done_i && is_rtmon && msg_irq_i &&
                   (msg_valid_i ? isq_valid_en_i : isq_invalid_en_i);
  assign isq_par = (rmi.par_err || par_pend) && is_rtmon && !isq_msg;
  always_ff @(posedge clk_i) begin
    if (isq_msg) begin
      isq[isq_wptr_o] <= msg_status_i;
      isq[isq_wptr_o + 6'd1] <= msg_desc_i;
    end else if (isq_par) begin
      isq[isq_wptr_o] <= ISQ_PAR_TAG;
      isq[isq_wptr_o + 6'd1] <= {4'h0, rmi.par_err ? rmi.par_addr : par_addr_q};
    end
  end
  // a parity report colliding with a message waits for the first cycle with no message entry
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      isq_wptr_o <= '0;
      par_pend <= 1'b0;
      par_addr_q <= '0;
      isq_rdata_o <= '0;
    end else begin
      isq_rdata_o <= isq[isq_raddr_i];
      if (isq_msg || isq_par) begin
        isq_wptr_o <= isq_wptr_o + 6'd2;
      end
      par_pend <= (rmi.par_err || par_pend) && isq_msg && is_rtmon;
      if (rmi.par_err) begin
        par_addr_q <= rmi.par_addr;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/titst_props.sv */
// concurrent checks on the interrupt, mask and time tag ports
`timescale 1ns/1ps
`default_nettype none
module titst_props import titst_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // inputs
  input wire logic [1:0] int_mode_i,
  input wire logic enh_int_i,
  input wire logic [15:0] evt1_i,
  input wire logic [15:0] evt2_i,
  input wire logic [3:0] user_irq_i,
  input wire logic stat1_rd_i,
  input wire logic stat2_rd_i,
  input wire logic int_clear_i,
  input wire logic mask1_we_i,
  input wire logic [15:0] mask_wdata_i,
  input wire logic tt_we_i,
  input wire logic [15:0] tt_wdata_i,
  input wire logic sync_nodata_i,
  // outputs
  input wire logic [15:0] mask1_o,
  input wire logic [15:0] mask2_o,
  input wire logic [15:0] stat1_o,
  input wire logic [15:0] stat2_o,
  input wire logic int_o,
  input wire logic [15:0] tt_count_o,
  input wire logic st_busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  AST_STD_MASK: assert property (!$past(enh_int_i) |-> ~|(stat1_o & ~$past(stat1_o) & ~$past(mask1_o)))
    else $error("status set with mask clear");
  AST_CHAIN: assert property ($past(enh_int_i) && |(stat1_o & ~$past(stat1_o)) |-> stat2_o[IS2_CHAIN])
    else $error("chain bit missing");
  AST_INT_GATED: assert property ($rose(int_o) |-> |(stat1_o & mask1_o) || |(stat2_o & mask2_o))
    else $error("interrupt without enabled status");
  AST_PULSE: assert property (int_o && int_mode_i == INT_PULSE |=> !int_o)
    else $error("pulse too long");
  AST_LEVEL_HOLD: assert property (int_o && int_mode_i == INT_LEVEL_SW && !int_clear_i |=> int_o)
    else $error("level dropped without clear");
  AST_AUTO_CLR: assert property (int_o && int_mode_i == INT_LEVEL_AUTO && (stat1_rd_i || stat2_rd_i)
    && !(|evt1_i || |evt2_i || |user_irq_i) |=> !int_o) else $error("level kept after read");
  AST_TT_LOAD: assert property (tt_we_i && !sync_nodata_i |-> ##2 tt_count_o == $past(tt_wdata_i, 2))
    else $error("time tag load lost");
  AST_MASK_WR: assert property (mask1_we_i && !st_busy_o |=> mask1_o == $past(mask_wdata_i))
    else $error("mask write lost");
  CV_PULSE: cover property (int_o && int_mode_i == INT_PULSE);
  CV_AUTO: cover property (int_o && int_mode_i == INT_LEVEL_AUTO && stat1_rd_i);
  CV_WRAP: cover property ($rose(stat1_o[IS1_TT_ROLL]));
endmodule
bind titst_top titst_props props (.*);
`default_nettype wire

/* testbench/titst_ram_model.sv */
// shared ram beside the block, one cycle read latency, parity fault on demand
`timescale 1ns/1ps
`default_nettype none
module titst_ram_model (
  // clock
  input wire logic clk_i,
  // ram pins
  input wire logic [11:0] addr_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [16:0] wdata_i,
  input wire logic flip_i,
  output logic [16:0] rdata_o
);
  logic [16:0] mem [4096];
  initial rdata_o = '0;
  always @(posedge clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    // idle bus shows the inverse, so stale data cannot pass
    rdata_o <= re_i ? mem[addr_i] ^ {flip_i, 16'h0000} : ~rdata_o;
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the interrupt, time tag and self-test block
`timescale 1ns/1ps
`default_nettype none
module tb import titst_pkg::*;;
  logic clk_i = '0, resetn_i = '0, enh_int_i = 1'h1, mask1_we_i = '0, mask2_we_i = '0, stat1_rd_i = '0;
  logic stat2_rd_i = '0, int_clear_i = '0, tt_sw_mode_i = '0, tt_sw_inc_i = '0, tt_we_i = '0, sync_clr_en_i = '0;
  logic sync_load_en_i = '0, sync_filter_i = '0, sync_nodata_i = '0, sync_data_i = '0, seq_tt_load_i = '0;
  logic seq_tt_queue_i = '0, msg_done_i = '0, st_start_i = '0, st_ram_sel_i = '0, ram_req_i = '0, ram_we_i = '0;
  logic par_flip = '0, enh_bc_i, single_ended_i, rx_pos_i, rx_neg_i, msg_valid_i, msg_irq_i;
  logic isq_valid_en_i, isq_invalid_en_i, dec_pos_o, dec_neg_o, int_o, gpq_we_o, desc_tt_we_o, st_busy_o;
  logic st_prot_fail_o, st_ram_fail_o, ram_rvalid_o, ram_we_o, ram_re_o;
  logic [1:0] mode_i = MODE_RT, int_mode_i = '0, freq_sel_i;
  logic [2:0] tt_res_i;
  logic [3:0] user_irq_i = '0;
  logic [5:0] isq_raddr_i, isq_wptr_o, fail_target_o;
  logic [11:0] ram_addr_i = '0, fail_rom_addr_o, ram_addr_o;
  logic [15:0] mask_wdata_i = '0, evt1_i = '0, evt2_i = '0, tt_wdata_i = '0, sync_word_i = '0, seq_tt_value_i = '0;
  logic [15:0] ram_wdata_i = '0, msg_status_i, msg_desc_i, mask1_o, mask2_o, stat1_o, stat2_o, tt_count_o;
  logic [15:0] bc_sync_word_o, gpq_data_o, desc_tt_o, isq_rdata_o, rt_bit_word_o, fail_actual_o, ram_rdata_o;
  logic [15:0] m, e, x, w, t;
  logic [16:0] ram_rdata_i, ram_wdata_o;
  logic [23:0] fail_expect_o;
  int fails = 0, n_compared = 0, cyc = 0;
  titst_top #(.PST_LEN(200)) dut (.*);
  titst_ram_model ram (.clk_i(clk_i), .addr_i(ram_addr_o), .we_i(ram_we_o), .re_i(ram_re_o),
    .wdata_i(ram_wdata_o), .flip_i(par_flip), .rdata_o(ram_rdata_i));
  initial forever #2 clk_i = ~clk_i;
  task automatic chk(string nm, logic [16:0] seen, logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge clk_i);
    s = '0;
  endtask
  task automatic wait_idle();
    repeat (2) @(negedge clk_i);
    repeat (20000) if (st_busy_o !== 1'h0) @(negedge clk_i);
  endtask
  task automatic final_report();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // noise on unchecked inputs keeps their logic busy
  initial begin
    void'($urandom(32'hCEE9E606));
    freq_sel_i = 2'($urandom);
    forever begin
      {rx_pos_i, rx_neg_i, single_ended_i, enh_bc_i, msg_valid_i, msg_irq_i, isq_valid_en_i} = 7'($urandom);
      {isq_invalid_en_i, isq_raddr_i, tt_res_i} = {7'($urandom), 3'($urandom % 6)};
      {msg_status_i, msg_desc_i} = $urandom;
      @(negedge clk_i);
    end
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(negedge clk_i);
    resetn_i = 1'h1;
    wait_idle();
    chk("prot fail", st_prot_fail_o, '0);
    chk("bit word", rt_bit_word_o[BIT_FAIL_POS], '0);
    chk("test done", stat2_o[IS2_SELFTEST], 1'h1);
    chk("masks", mask1_o, MASK_RST);
    $display("end power-up");
    for (int i = 0; i < 9; i++) begin
      int_mode_i = 2'(i % 3);
      enh_int_i = i[0];
      m = 16'($urandom);
      e = 16'($urandom & $urandom);
      mask_wdata_i = m;
      pulse(mask1_we_i);
      evt1_i = e;
      @(negedge clk_i);
      evt1_i = '0;
      x = enh_int_i ? e : e & m;
      chk("stat1", stat1_o, x);
      if (enh_int_i) chk("chain", stat2_o[IS2_CHAIN], |x);
      chk("int", int_o, |(e & m));
      @(negedge clk_i);
      chk("int held", int_o, int_mode_i != INT_PULSE && |(e & m));
      stat1_rd_i = 1'h1;
      int_clear_i = int_mode_i == INT_LEVEL_SW;
      @(negedge clk_i);
      {stat1_rd_i, int_clear_i} = '0;
      @(negedge clk_i);
      chk("int off", int_o, '0);
      pulse(int_clear_i);
    end
    $display("end interrupts");
    enh_int_i = 1'h1;
    tt_sw_mode_i = 1'h1;
    tt_wdata_i = TT_MAX - 16'h0001;
    pulse(tt_we_i);
    repeat (2) begin
      pulse(tt_sw_inc_i);
      @(negedge clk_i);
    end
    @(negedge clk_i);
    chk("tt wrap", tt_count_o, TT_RST);
    chk("wrap flag", stat1_o[IS1_TT_ROLL], 1'h1);
    {sync_load_en_i, sync_filter_i} = 2'h3;
    t = TT_RST;
    for (int k = 0; k < 2; k++) begin
      w = 16'($urandom);
      w[0] = k[0];
      if (!w[0]) t = w;
      sync_word_i = w;
      pulse(sync_data_i);
      @(negedge clk_i);
      chk("sync load", tt_count_o, t);
    end
    sync_clr_en_i = 1'h1;
    pulse(sync_nodata_i);
    @(negedge clk_i);
    chk("sync clear", tt_count_o, TT_RST);
    mode_i = MODE_BC;
    seq_tt_value_i = w;
    pulse(seq_tt_load_i);
    @(negedge clk_i);
    pulse(seq_tt_queue_i);
    chk("queue", {gpq_we_o, gpq_data_o}, {1'h1, w});
    pulse(msg_done_i);
    chk("desc tag", {desc_tt_we_o, desc_tt_o}, {1'h1, w});
    chk("bc sync", bc_sync_word_o, w);
    $display("end time tag");
    w = 16'($urandom);
    {ram_addr_i, ram_wdata_i, ram_we_i} = {12'($urandom), w, 1'h1};
    pulse(ram_req_i);
    chk("ram write", ram_wdata_o, {^w, w});
    ram_we_i = '0;
    for (int k = 0; k < 2; k++) begin
      par_flip = k[0];
      pulse(ram_req_i);
      repeat (2) @(negedge clk_i);
      chk("ram read", {ram_rvalid_o, ram_rdata_o}, {1'h1, w});
    end
    @(negedge clk_i);
    par_flip = '0;
    chk("parity flag", stat1_o[IS1_PARITY], 1'h1);
    st_ram_sel_i = 1'h1;
    pulse(st_start_i);
    wait_idle();
    chk("ram test", st_ram_fail_o, '0);
    chk("ram left", ram.mem[5][11:0], 12'(~12'h005));
    $display("end ram");
    final_report();
  end
endmodule
`default_nettype wire
